// File: pkg/timer_regs.svh
// Constants of the 8/16-bit timer: widths, field positions, reset values, codes.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define TC_CNT_W      8
`define TC_PRE_W      15
`define TC_SEL_W      4
`define TC_NSRC       5

`define TC_LOW_RST    8'h00
`define TC_HIGH_RST   8'hFF
`define TC_CTRLA_RST  8'h00
`define TC_CTRLB_RST  8'h00
`define TC_WIDE_MAX   16'hFFFF

`define TC_A_EN       7
`define TC_A_RSVD     6
`define TC_A_OUT      5
`define TC_A_WIDE     4
`define TC_A_POST_HI  3
`define TC_A_POST_LO  0

`define TC_B_SRC_HI   7
`define TC_B_SRC_LO   5
`define TC_B_ASYNC    4
`define TC_B_PRE_HI   3
`define TC_B_PRE_LO   0

`define TC_SRC_PIN    3'h0
`define TC_SRC_PINN   3'h1
`define TC_SRC_INSTR  3'h2
`define TC_SRC_HF     3'h3
`define TC_SRC_LF     3'h4
`define TC_SRC_RSVD   3'h5
`define TC_SRC_SOSC   3'h6
`define TC_SRC_LOGIC  3'h7

`define TC_I_PIN      0
`define TC_I_HF       1
`define TC_I_LF       2
`define TC_I_SOSC     3
`define TC_I_LOGIC    4

// System clock divided by four gives the instruction cycle
`define TC_INSTR_LAST 2'h3

`endif

// File: pkg/timer_pkg.sv
// Types shared by the timer top and its prescaler.
// Assumes timer_regs.svh is on the include path.
`include "timer_regs.svh"
`default_nettype none
package timer_pkg;

  typedef enum logic [2:0] {
    SRC_PIN   = `TC_SRC_PIN,
    SRC_PINN  = `TC_SRC_PINN,
    SRC_INSTR = `TC_SRC_INSTR,
    SRC_HF    = `TC_SRC_HF,
    SRC_LF    = `TC_SRC_LF,
    SRC_RSVD  = `TC_SRC_RSVD,
    SRC_SOSC  = `TC_SRC_SOSC,
    SRC_LOGIC = `TC_SRC_LOGIC
  } src_sel_t;

  typedef struct packed {
    logic [`TC_PRE_W-1:0] cnt;
  } pre_state_t;

  typedef struct packed {
    logic [`TC_NSRC-1:0]  sync1;
    logic [`TC_NSRC-1:0]  sync2;
    logic [`TC_NSRC-1:0]  prev;
    logic                 pend;
    logic [1:0]           div;
    logic [7:0]           ctrl_a;
    logic [7:0]           ctrl_b;
    logic [`TC_CNT_W-1:0] low;
    logic [`TC_CNT_W-1:0] high;
    logic [`TC_CNT_W-1:0] high_buf;
    logic [`TC_CNT_W-1:0] period_buf;
    logic [`TC_SEL_W-1:0] post_cnt;
    logic                 pulse;
    logic                 out;
    logic                 flag;
  } timer_state_t;

endpackage : timer_pkg
`default_nettype wire

// File: pkg/prescale_if.sv
// Link between the timer core and its dedicated prescaler.
// Assumes both ends run on the same clock.
`include "timer_regs.svh"
`default_nettype none
interface prescale_if;
  logic                 tick_in;
  logic                 clear;
  logic [`TC_SEL_W-1:0] sel;
  logic                 tick_out;
  logic [`TC_PRE_W-1:0] count;

  modport ctl    (output tick_in, output clear, output sel, input tick_out, input count);
  modport scaler (input tick_in, input clear, input sel, output tick_out, output count);
endinterface : prescale_if
`default_nettype wire

// File: hw/prescaler.sv
// Dedicated 15-bit power-of-two prescaler ahead of the timer count input.
// Assumes a synchronous active-low reset copy and single-cycle input ticks.
`include "timer_regs.svh"
`default_nettype none
module prescaler (
  input  wire logic     clk_in,
  input  wire logic     rst_n_in,
  prescale_if.scaler    pif
);
  import timer_pkg::*;

  pre_state_t s_q;
  pre_state_t s_d;
  logic [`TC_PRE_W-1:0] mask;

  function automatic logic [`TC_PRE_W-1:0] ratio_mask(input logic [`TC_SEL_W-1:0] sel);
    logic [`TC_PRE_W:0] full;
    full = (`TC_PRE_W+1)'((`TC_PRE_W+1)'(1) << sel);
    return `TC_PRE_W'(full - (`TC_PRE_W+1)'(1));
  endfunction : ratio_mask

  always_comb begin
    s_d  = s_q;
    mask = ratio_mask(pif.sel);
    if (pif.clear) begin
      s_d.cnt = '0;
    end else if (pif.tick_in) begin
      s_d.cnt = `TC_PRE_W'(s_q.cnt + `TC_PRE_W'(1));
    end
  end

  // Select 0 gives an all-zero mask, so every input tick passes
  assign pif.tick_out = pif.tick_in & ((s_q.cnt & mask) == mask);
  assign pif.count    = s_q.cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  bypass_pass_a : assert property ((pif.sel == '0) && pif.tick_in |-> pif.tick_out)
    else $error("prescaler bypass dropped a tick");
  // Checked against the power-of-two ratio itself, not against the mask function
  ratio_mask_a : assert property (pif.tick_out |->
    (((16'(pif.count) + 16'h0001) & ((16'h0001 << pif.sel) - 16'h0001)) == 16'h0000))
    else $error("prescaler fired off its ratio");
  clear_zero_a : assert property (pif.clear |=> (pif.count == '0))
    else $error("prescaler not cleared");
endmodule : prescaler
`default_nettype wire

// File: hw/timer_counter.sv
// Top of the 8/16-bit timer/counter with prescaler, postscaler and event flag.
// Assumes register accesses arrive as one-cycle strobes on clk_in; sources are async.
`include "timer_regs.svh"
`default_nettype none
module timer_counter (
  input  wire logic                 clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic                 src_pin_in,
  input  wire logic                 src_hf_in,
  input  wire logic                 src_lf_in,
  input  wire logic                 src_sosc_in,
  input  wire logic                 src_logic_in,
  input  wire logic [7:0]           wr_data_in,
  input  wire logic                 wr_low_in,
  input  wire logic                 wr_high_in,
  input  wire logic                 wr_ctrl_a_in,
  input  wire logic                 wr_ctrl_b_in,
  input  wire logic                 rd_low_in,
  input  wire logic                 flag_clear_in,
  output logic [`TC_CNT_W-1:0]      count_low_byte_out,
  output logic [`TC_CNT_W-1:0]      high_buffer_or_period_out,
  output logic [`TC_CNT_W-1:0]      period_buffer_out,
  output logic [7:0]                timer_control_a_out,
  output logic [7:0]                timer_control_b_out,
  output logic                      match_pulse_out,
  output logic                      timer_event_output_out,
  output logic                      timer_interrupt_flag_out
);
  import timer_pkg::*;

  logic [1:0]   rst_sync_q;
  logic         rst_n;
  timer_state_t s_q;
  timer_state_t s_d;
  prescale_if   pif ();

  logic         en;
  logic         wide;
  logic         async_sel;
  src_sel_t     src;
  logic         instr;
  logic         edge_seen;
  logic         sync_edge;
  logic         raw_tick;
  logic         cnt_tick;
  logic         match;
  logic         wrap;
  logic         evt;
  logic         fire;
  logic [15:0]  wide_next;

  // Pin-facing sources: the first stage is read only by the second
  function automatic logic src_level(input src_sel_t sel, input logic [`TC_NSRC-1:0] v);
    logic lvl;
    lvl = 1'h0;
    unique case (sel)
      SRC_PIN:   lvl = v[`TC_I_PIN];
      SRC_PINN:  lvl = ~v[`TC_I_PIN];
      SRC_HF:    lvl = v[`TC_I_HF];
      SRC_LF:    lvl = v[`TC_I_LF];
      SRC_SOSC:  lvl = v[`TC_I_SOSC];
      SRC_LOGIC: lvl = v[`TC_I_LOGIC];
      SRC_INSTR, SRC_RSVD: lvl = 1'h0;
    endcase
    return lvl;
  endfunction : src_level

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Prescaler has no link to any watchdog logic
  prescaler u_prescaler (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .pif      (pif)
  );

  always_comb begin
    s_d       = s_q;
    en        = s_q.ctrl_a[`TC_A_EN];
    wide      = s_q.ctrl_a[`TC_A_WIDE];
    async_sel = s_q.ctrl_b[`TC_B_ASYNC];
    src       = src_sel_t'(s_q.ctrl_b[`TC_B_SRC_HI:`TC_B_SRC_LO]);
    s_d.sync1 = {src_logic_in, src_sosc_in, src_lf_in, src_hf_in, src_pin_in};
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.div   = 2'(s_q.div + 2'h1);
    instr     = (s_q.div == `TC_INSTR_LAST);
    edge_seen = src_level(src, s_q.sync2) & ~src_level(src, s_q.prev);
    // Synchronous mode holds an edge until the next instruction cycle
    sync_edge = s_q.pend | edge_seen;
    s_d.pend  = 1'h0;
    if (src == SRC_INSTR) begin
      raw_tick = instr;
    end else if (async_sel) begin
      raw_tick = edge_seen;
    end else begin
      raw_tick = instr & sync_edge;
      s_d.pend = sync_edge & ~instr & en;
    end
    pif.tick_in = en & raw_tick;
    pif.clear   = wr_low_in | wr_ctrl_a_in | wr_ctrl_b_in;
    pif.sel     = s_q.ctrl_b[`TC_B_PRE_HI:`TC_B_PRE_LO];
    cnt_tick    = pif.tick_out;
    match       = ~wide & (s_q.low == s_q.high_buf);
    wrap        = wide & ({s_q.high, s_q.low} == `TC_WIDE_MAX);
    evt         = cnt_tick & (match | wrap);
    wide_next   = 16'({s_q.high, s_q.low} + 16'h0001);
    fire        = 1'h0;
    if (cnt_tick) begin
      s_d.pulse = match | wrap;
      if (wide) begin
        {s_d.high, s_d.low} = wide_next;
      end else if (match) begin
        s_d.low        = `TC_LOW_RST;
        s_d.period_buf = s_q.high_buf;
      end else begin
        s_d.low = `TC_CNT_W'(s_q.low + `TC_CNT_W'(1));
      end
    end
    if (!en) begin
      s_d.pulse = 1'h0;
    end
    if (evt) begin
      if (s_q.post_cnt == s_q.ctrl_a[`TC_A_POST_HI:`TC_A_POST_LO]) begin
        s_d.post_cnt = '0;
        fire         = 1'h1;
      end else begin
        s_d.post_cnt = `TC_SEL_W'(s_q.post_cnt + `TC_SEL_W'(1));
      end
    end
    if (fire) begin
      s_d.out = ~s_q.out;
    end
    // Set beats a clear arriving in the same cycle
    s_d.flag = (s_q.flag & ~flag_clear_in) | fire;
    // Software accesses take priority over a coincident count
    if (rd_low_in && wide) begin
      s_d.high_buf = s_q.high;
    end
    if (wr_high_in) begin
      s_d.high_buf = wr_data_in;
    end
    if (wr_low_in) begin
      s_d.low = wr_data_in;
      if (wide) begin
        s_d.high = s_q.high_buf;
      end
    end
    if (wr_ctrl_a_in) begin
      s_d.ctrl_a = wr_data_in;
      s_d.ctrl_a[`TC_A_RSVD] = 1'h0;
      s_d.ctrl_a[`TC_A_OUT]  = 1'h0;
    end
    if (wr_ctrl_b_in) begin
      s_d.ctrl_b = wr_data_in;
    end
    if (pif.clear) begin
      s_d.post_cnt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.ctrl_a   <= `TC_CTRLA_RST;
      s_q.ctrl_b   <= `TC_CTRLB_RST;
      s_q.low      <= `TC_LOW_RST;
      s_q.high_buf <= `TC_HIGH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    timer_control_a_out = s_q.ctrl_a;
    timer_control_a_out[`TC_A_OUT] = s_q.out;
  end
  assign timer_control_b_out       = s_q.ctrl_b;
  assign count_low_byte_out        = s_q.low;
  assign high_buffer_or_period_out = s_q.high_buf;
  assign period_buffer_out         = s_q.period_buf;
  assign match_pulse_out           = s_q.pulse;
  assign timer_event_output_out    = s_q.out;
  assign timer_interrupt_flag_out  = s_q.flag;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence seq_quiet;
    !wr_low_in && !wr_high_in && !wr_ctrl_a_in && !wr_ctrl_b_in;
  endsequence
  sequence seq_match_tick;
    cnt_tick && !wide && (s_q.low == s_q.high_buf) && !wr_low_in && !wr_high_in;
  endsequence

  reset_values_a : assert property ($rose(rst_n) |->
    (s_q.low == `TC_LOW_RST) && (s_q.high_buf == `TC_HIGH_RST))
    else $error("reset values wrong");
  match_reload_a : assert property (seq_match_tick |=>
    (s_q.low == `TC_LOW_RST) && (s_q.period_buf == $past(s_q.high_buf)) && s_q.pulse)
    else $error("8-bit match did not reload");
  wide_wrap_a : assert property (((cnt_tick && wide &&
    ({s_q.high, s_q.low} == `TC_WIDE_MAX)) and seq_quiet) |=>
    ({s_q.high, s_q.low} == 16'h0000))
    else $error("16-bit wrap wrong");
  high_latch_a : assert property (rd_low_in && wide && !wr_high_in |=>
    s_q.high_buf == $past(s_q.high))
    else $error("low read did not latch high");
  high_load_a : assert property (wr_low_in && wide |=>
    (s_q.high == $past(s_q.high_buf)) && (s_q.low == $past(wr_data_in)))
    else $error("low write did not load high");
  post_flag_a : assert property (evt && !pif.clear &&
    (s_q.post_cnt == s_q.ctrl_a[`TC_A_POST_HI:`TC_A_POST_LO]) |=>
    s_q.flag && (s_q.out != $past(s_q.out)))
    else $error("postscaled event lost");
  flag_only_fire_a : assert property (!s_q.flag ##1 s_q.flag |-> $past(evt))
    else $error("flag set without event");
  hold_disabled_a : assert property ((!en and seq_quiet) |=>
    $stable({s_q.high, s_q.low}) && !s_q.pulse && $stable(s_q.out))
    else $error("disabled counter moved");
  sync_rate_a : assert property (cnt_tick && !async_sel |-> instr)
    else $error("synchronous count off instruction cycle");
  post_clear_a : assert property (pif.clear |=> s_q.post_cnt == 4'h0)
    else $error("postscaler not cleared");
endmodule : timer_counter
`default_nettype wire

// File: dv/src_model.sv
// Count sources outside the timer: pin, two oscillators, slow oscillator, logic cell.
// Assumes the bench calls burst; every line rests low between bursts.
`default_nettype none
module src_model (
  output logic [4:0] lines_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lines_out = 5'h00;
  // Slow edges, so the synchronised path cannot miss one
  task automatic burst(input int idx, input int n);
    for (int i = 0; i < n; i++) begin
      lines_out[idx] = 1'b1;
      #40;
      lines_out[idx] = 1'b0;
      #40;
    end
  endtask : burst
endmodule : src_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench of the timer/counter top.
// Assumes one-cycle strobes given at the falling edge of clk_in.
`include "timer_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W_LOW = 0, W_HIGH = 1, W_CA = 2, W_CB = 3, R_LOW = 4, F_CLR = 5;
  logic       clk_in    = 1'b0;
  logic       arst_n_in = 1'b0;
  logic [7:0] wdat      = 8'h00;
  logic [5:0] stb       = 6'h00;
  wire  [4:0] src;
  logic [7:0] low, hi, pbuf, ca, cb;
  logic       mp, evo, flg;
  int         n_mismatch = 0;
  int         n_tests    = 0;
  always #5 clk_in = ~clk_in;
  src_model i_src (.lines_out(src));
  timer_counter i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .src_pin_in(src[0]), .src_hf_in(src[1]),
    .src_lf_in(src[2]), .src_sosc_in(src[3]), .src_logic_in(src[4]), .wr_data_in(wdat),
    .wr_low_in(stb[W_LOW]), .wr_high_in(stb[W_HIGH]), .wr_ctrl_a_in(stb[W_CA]),
    .wr_ctrl_b_in(stb[W_CB]), .rd_low_in(stb[R_LOW]), .flag_clear_in(stb[F_CLR]),
    .count_low_byte_out(low), .high_buffer_or_period_out(hi), .period_buffer_out(pbuf),
    .timer_control_a_out(ca), .timer_control_b_out(cb), .match_pulse_out(mp),
    .timer_event_output_out(evo), .timer_interrupt_flag_out(flg));
  task automatic end_sim();
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic strobe(input int k, input logic [7:0] d);
    @(negedge clk_in);
    wdat   = d;
    stb[k] = 1'b1;
    @(negedge clk_in);
    stb[k] = 1'b0;
  endtask : strobe
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle
  // A pulse still high from an older event is not taken as a new one
  task automatic wait_rise();
    logic p;
    for (int t = 0; t < 400; t++) begin
      p = mp;
      @(negedge clk_in);
      if (mp === 1'b1 && p !== 1'b1) return;
    end
    chk("event wait", 16'h0, 16'h1);
  endtask : wait_rise
  // First change aligns to a tick, second gives the spacing
  task automatic gap(output int c);
    logic [7:0] v;
    c = 0;
    for (int k = 0; k < 2; k++) begin
      v = low;
      c = 0;
      while (low === v && c < 1200) begin
        @(negedge clk_in);
        c++;
      end
    end
  endtask : gap
  int         sels[4]  = '{0, 1, 2, 7};
  logic [2:0] codes[8] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h7, 3'h5};
  logic       asy[8]   = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int         lines[8] = '{0, 0, 0, 1, 2, 3, 4, 0};
  logic [7:0] expn[8]  = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h00};
  initial begin
    int c;
    idle(10);
    arst_n_in = 1'b1;
    idle(3);
    chk("low reset", low, `TC_LOW_RST);
    chk("period reset", hi, `TC_HIGH_RST);
    chk("flag reset", flg, 1'b0);
    strobe(W_HIGH, 8'h02);
    strobe(W_CB, 8'h40);
    chk("control b", cb, 8'h40);
    strobe(W_LOW, 8'h00);
    strobe(W_CA, 8'h80);
    wait_rise();
    chk("low at match", low, 8'h00);
    chk("period copy", pbuf, 8'h02);
    chk("flag at match", flg, 1'b1);
    chk("output first", evo, 1'b1);
    chk("output readback", ca, 8'hA0);
    wait_rise();
    chk("output second", evo, 1'b0);
    strobe(W_CA, 8'h62);
    strobe(F_CLR, 8'h00);
    chk("control a", ca, 8'h02);
    strobe(W_LOW, 8'h00);
    strobe(W_CA, 8'h82);
    wait_rise();
    wait_rise();
    chk("flag second", flg, 1'b0);
    wait_rise();
    chk("flag third", flg, 1'b1);
    strobe(W_HIGH, 8'hFF);
    strobe(W_CA, 8'h80);
    foreach (sels[i]) begin
      strobe(W_CB, 8'h40 | 8'(sels[i]));
      gap(c);
      chk("prescale gap", 16'(c), 16'(4 << sels[i]));
    end
    strobe(W_CA, 8'h10);
    strobe(W_CB, 8'h40);
    strobe(W_HIGH, 8'hFF);
    strobe(W_LOW, 8'hFE);
    strobe(W_HIGH, 8'h55);
    strobe(R_LOW, 8'h00);
    idle(1);
    chk("wide read", {hi, low}, 16'hFFFE);
    strobe(F_CLR, 8'h00);
    strobe(W_CA, 8'h90);
    wait_rise();
    chk("wrap flag", flg, 1'b1);
    strobe(R_LOW, 8'h00);
    idle(1);
    chk("wrap high", hi, 8'h00);
    strobe(W_CA, 8'h00);
    strobe(W_LOW, 8'h77);
    idle(40);
    chk("hold low", low, 8'h77);
    chk("hold pulse", mp, 1'b0);
    strobe(W_HIGH, 8'hFF);
    strobe(W_CA, 8'h80);
    foreach (codes[i]) begin
      strobe(W_CB, {codes[i], asy[i], 4'h0});
      strobe(W_LOW, 8'h00);
      i_src.burst(lines[i], 5);
      idle(10);
      chk("source count", low, expn[i]);
    end
    end_sim();
  end
  // Whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
